// ### hdl/ddcs_top.sv
// Display data channel slave: 256-byte buffer, legacy one-way mode
// clocked by vertical sync, and a two-wire DDC2b slave.
// Assumes an 8-bit special function register port, an xdata port for
// FF00h-FFFFh, and the I2C enable bit supplied by the I2C controller.
// How it works
// - Served data lives in a 256-byte buffer loaded by the processor.
// - The unit is only ever a slave; it never starts a transfer.
// - An 8-bit read/write register holds the next byte to send.
// - Pointer post-increments after every buffer window access made with service set.
// - Size select clear gives 128 bytes, set gives 256 bytes.
// - Software service clear: bytes fetched from buffer at pointer.
// - Software service set: processor interrupted to load each byte.
// - DDC2b address A0/A1, or low three bits ignored when masked.
// - Legacy flag set on ninth sync clock of each byte, with service set only; software clears it.
// - Legacy enable clear ignores vertical sync; DDC2b still answers.
// - Mode switch flag set on legacy to DDC2b move; software clears.
// - Mode bit 1 means DDC2b; sticks until disabled or reset.
// - Enabled when legacy enable or I2C enable is set.
// - Disabled, service clear: no buffer access, xdata goes external.
// - Disabled, service set: processor preloads buffer at FF00h-FFFFh.
// - Enabled, service clear: only the unit uses the buffer.
// - Enabled, service set: interrupt per byte, byte held in shift data.
// - The attached host type is detected and reported.
// - Eight sync clocks for synchronisation, data pin released meanwhile; first bit sent on the ninth.
// - Clock line held low while software owes a byte.
`timescale 1ns/1ps
module ddcs_top (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   input wire logic [15:0] i_xd_addr,
   input wire logic i_xd_wr,
   input wire logic i_xd_rd,
   input wire logic [7:0] i_xd_wdata,
   output logic [7:0] o_xd_rdata,
   output logic o_xd_sel,
   input wire logic i_i2c_enable,
   input wire logic i_vsync,
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe_n,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe_n,
   output logic [7:0] o_shift_data,
   output logic o_irq,
   output logic [1:0] o_host_type
);
   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] tx_byte;
      logic [7:0] ptr;
      logic size;
      logic sw;
      logic ax;
      logic d1_flag;
      logic d1_en;
      logic sw_flag;
      logic mode;
      logic [7:0] sfr_rdata;
      logic [7:0] xd_rdata;
      logic [7:0] shift_data;
      logic [3:0] sync_cnt;
      logic [3:0] bit_pos;
      logic [7:0] d1_sh;
      logic d1_low;
      ddcs_pkg::ddcs_i2c_e st;
      logic [7:0] i2c_sh;
      logic [3:0] i2c_cnt;
      logic rw;
      logic first;
      logic i2c_low;
      logic pending;
      logic stretch;
      logic scl_p;
      logic sda_p;
      logic vs_p;
      ddcs_pkg::ddcs_host_e host;
   } ddcs_state_s;

   ddcs_state_s s_q;
   ddcs_state_s s_d;
   logic [7:0] mem [ddcs_pkg::BUF_DEPTH];
   logic mem_we;
   logic [7:0] mem_wa;
   logic [7:0] mem_wd;
   logic [2:0] pins_s;
   logic vs_s;
   logic scl_s;
   logic sda_s;
   logic enabled;
   logic [7:0] mask;
   logic [7:0] ptr_inc;
   logic [7:0] fetch;
   logic vs_rise;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic xd_hit;
   logic addr_ok;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   ddcs_sync #(.W(3), .INIT(3'h7)) u_sync (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async({i_vsync, i_scl, i_sda}),
      .o_sync(pins_s)
   );
   assign vs_s = pins_s[2];
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      mem_we = 1'b0;
      mem_wa = s_q.ptr;
      mem_wd = 8'h00;
      enabled = s_q.d1_en | i_i2c_enable;
      mask = s_q.size ? ddcs_pkg::MASK_LARGE : ddcs_pkg::MASK_SMALL;
      ptr_inc = (s_q.ptr + 8'h01) & mask;
      fetch = s_q.sw ? s_q.tx_byte : mem[s_q.ptr];
      vs_rise = vs_s & ~s_q.vs_p;
      scl_rise = scl_s & ~s_q.scl_p;
      scl_fall = ~scl_s & s_q.scl_p;
      start = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
      stop = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
      xd_hit = (i_xd_addr[15:8] == ddcs_pkg::XDATA_PAGE) &
               (enabled | s_q.sw);
      addr_ok = s_q.ax ?
                (s_q.i2c_sh[7:4] == ddcs_pkg::SLAVE_ADDR[6:3]) :
                (s_q.i2c_sh[7:1] == ddcs_pkg::SLAVE_ADDR);
      s_d.vs_p = vs_s;
      s_d.scl_p = scl_s;
      s_d.sda_p = sda_s;

      // Register writes
      if (i_sfr_wr) begin
         case (i_sfr_addr)
            ddcs_pkg::OFS_BUFFER_WINDOW: begin
               if (s_q.sw) begin
                  mem_we = 1'b1;
                  mem_wd = i_sfr_wdata;
                  s_d.ptr = ptr_inc;
               end
            end
            ddcs_pkg::OFS_LEGACY_TX_BYTE: begin
               s_d.tx_byte = i_sfr_wdata;
               s_d.pending = 1'b0;
            end
            ddcs_pkg::OFS_BUFFER_POINTER: s_d.ptr = i_sfr_wdata;
            ddcs_pkg::OFS_CHANNEL_CONTROL: begin
               s_d.size = i_sfr_wdata[ddcs_pkg::BIT_SIZE_SELECT];
               s_d.sw = i_sfr_wdata[ddcs_pkg::BIT_SOFTWARE_SERVICE];
               s_d.ax = i_sfr_wdata[ddcs_pkg::BIT_ADDRESS_MASK];
               s_d.d1_en = i_sfr_wdata[ddcs_pkg::BIT_LEGACY_ENABLE];
               s_d.d1_flag = s_q.d1_flag &
                             i_sfr_wdata[ddcs_pkg::BIT_LEGACY_IRQ_FLAG];
               s_d.sw_flag = s_q.sw_flag &
                             i_sfr_wdata[ddcs_pkg::BIT_MODE_SWITCH_FLAG];
            end
            default: ;
         endcase
      end

      // Register reads
      if (i_sfr_rd) begin
         case (i_sfr_addr)
            ddcs_pkg::OFS_BUFFER_WINDOW: begin
               s_d.sfr_rdata = 8'h00;
               if (s_q.sw) begin
                  s_d.sfr_rdata = mem[s_q.ptr];
                  s_d.ptr = ptr_inc;
               end
            end
            ddcs_pkg::OFS_LEGACY_TX_BYTE: s_d.sfr_rdata = s_q.tx_byte;
            ddcs_pkg::OFS_BUFFER_POINTER: s_d.sfr_rdata = s_q.ptr;
            ddcs_pkg::OFS_CHANNEL_CONTROL: begin
               s_d.sfr_rdata = {1'b0, s_q.size, s_q.sw, s_q.ax, s_q.d1_flag,
                                s_q.d1_en, s_q.sw_flag, s_q.mode};
            end
            default: s_d.sfr_rdata = 8'h00;
         endcase
      end

      // Direct buffer access in xdata space
      if (xd_hit & s_q.sw & i_xd_wr) begin
         mem_we = 1'b1;
         mem_wa = i_xd_addr[7:0];
         mem_wd = i_xd_wdata;
      end
      if (i_xd_rd) begin
         s_d.xd_rdata = (xd_hit & s_q.sw) ? mem[i_xd_addr[7:0]] : 8'h00;
      end

      // Legacy one-way link on vertical sync
      if (!s_q.d1_en || s_q.mode) begin
         s_d.sync_cnt = 4'h0;
         s_d.bit_pos = 4'h0;
         s_d.d1_low = 1'b0;
      end else if (vs_rise) begin
         if (s_q.host == ddcs_pkg::HOST_NONE) begin
            s_d.host = ddcs_pkg::HOST_LEGACY;
         end
         if (s_q.sync_cnt != ddcs_pkg::SYNC_CLOCKS) begin
            s_d.sync_cnt = s_q.sync_cnt + 4'h1;
            s_d.bit_pos = ddcs_pkg::IDLE_BIT_POS;
            s_d.d1_low = 1'b0;
         end
         if (s_q.sync_cnt == ddcs_pkg::SYNC_CLOCKS - 4'h1 ||
             (s_q.sync_cnt == ddcs_pkg::SYNC_CLOCKS &&
              s_q.bit_pos == ddcs_pkg::IDLE_BIT_POS)) begin
            s_d.d1_sh = fetch;
            s_d.d1_low = ~fetch[7];
            s_d.bit_pos = 4'h0;
            s_d.shift_data = fetch;
            if (s_q.sw) begin
               s_d.pending = 1'b1;
            end else begin
               s_d.ptr = ptr_inc;
            end
         end else if (s_q.sync_cnt == ddcs_pkg::SYNC_CLOCKS) begin
            s_d.bit_pos = s_q.bit_pos + 4'h1;
            s_d.d1_sh = {s_q.d1_sh[6:0], 1'b0};
            s_d.d1_low = ~s_q.d1_sh[6];
            if (s_q.bit_pos == ddcs_pkg::IDLE_BIT_POS - 4'h1) begin
               s_d.d1_low = 1'b0;
               if (s_q.sw) begin
                  s_d.d1_flag = 1'b1;
               end
            end
         end
      end

      // Mode tracking
      if (!enabled) begin
         s_d.mode = 1'b0;
      end else if (start && i_i2c_enable && !s_q.mode) begin
         s_d.mode = 1'b1;
         if (s_q.d1_en) begin
            s_d.sw_flag = 1'b1;
         end
      end

      // DDC2b slave; it only ever answers, never starts
      if (!i_i2c_enable) begin
         s_d.st = ddcs_pkg::I2C_IDLE;
         s_d.i2c_low = 1'b0;
      end else if (start) begin
         s_d.st = ddcs_pkg::I2C_ADDR;
         s_d.i2c_cnt = 4'h0;
         s_d.i2c_low = 1'b0;
      end else if (stop) begin
         s_d.st = ddcs_pkg::I2C_IDLE;
         s_d.i2c_low = 1'b0;
      end else begin
         case (s_q.st)
            ddcs_pkg::I2C_IDLE: s_d.i2c_low = 1'b0;
            ddcs_pkg::I2C_ADDR, ddcs_pkg::I2C_RX: begin
               if (scl_rise) begin
                  s_d.i2c_sh = {s_q.i2c_sh[6:0], sda_s};
                  s_d.i2c_cnt = s_q.i2c_cnt + 4'h1;
               end else if (scl_fall && s_q.i2c_cnt == 4'h8) begin
                  s_d.i2c_cnt = 4'h0;
                  if (s_q.st == ddcs_pkg::I2C_RX) begin
                     s_d.st = ddcs_pkg::I2C_ACK_DATA;
                     s_d.i2c_low = 1'b1;
                     s_d.shift_data = s_q.i2c_sh;
                     if (s_q.sw) begin
                        s_d.pending = 1'b1;
                     end else if (s_q.first) begin
                        s_d.ptr = s_q.i2c_sh;
                     end else begin
                        mem_we = 1'b1;
                        mem_wd = s_q.i2c_sh;
                        s_d.ptr = ptr_inc;
                     end
                     s_d.first = 1'b0;
                  end else if (addr_ok) begin
                     s_d.st = ddcs_pkg::I2C_ACK_ADDR;
                     s_d.i2c_low = 1'b1;
                     s_d.rw = s_q.i2c_sh[0];
                     s_d.host = ddcs_pkg::HOST_DDC2B;
                  end else begin
                     s_d.st = ddcs_pkg::I2C_IDLE;
                     if (s_q.i2c_sh[7:1] == ddcs_pkg::AB_HOST_ADDR) begin
                        s_d.host = ddcs_pkg::HOST_DDC2AB;
                     end
                  end
               end
            end
            ddcs_pkg::I2C_ACK_ADDR, ddcs_pkg::I2C_MACK: begin
               if (scl_rise && s_q.st == ddcs_pkg::I2C_MACK) begin
                  s_d.rw = ~sda_s;
               end else if (scl_fall) begin
                  s_d.i2c_low = 1'b0;
                  s_d.st = ddcs_pkg::I2C_IDLE;
                  if (s_q.rw) begin
                     s_d.st = ddcs_pkg::I2C_TX;
                     s_d.i2c_sh = fetch;
                     s_d.i2c_low = ~fetch[7];
                     s_d.shift_data = fetch;
                     s_d.i2c_cnt = 4'h0;
                     if (s_q.sw) begin
                        s_d.pending = 1'b1;
                     end else begin
                        s_d.ptr = ptr_inc;
                     end
                  end else if (s_q.st == ddcs_pkg::I2C_ACK_ADDR) begin
                     s_d.st = ddcs_pkg::I2C_RX;
                     s_d.first = 1'b1;
                     s_d.i2c_cnt = 4'h0;
                  end
               end
            end
            ddcs_pkg::I2C_TX: begin
               if (scl_fall) begin
                  s_d.i2c_cnt = s_q.i2c_cnt + 4'h1;
                  s_d.i2c_sh = {s_q.i2c_sh[6:0], 1'b0};
                  s_d.i2c_low = ~s_q.i2c_sh[6];
                  if (s_q.i2c_cnt == 4'h7) begin
                     s_d.st = ddcs_pkg::I2C_MACK;
                     s_d.i2c_low = 1'b0;
                  end
               end
            end
            ddcs_pkg::I2C_ACK_DATA: begin
               if (scl_fall) begin
                  s_d.st = ddcs_pkg::I2C_RX;
                  s_d.i2c_low = 1'b0;
               end
            end
            default: s_d.st = ddcs_pkg::I2C_IDLE;
         endcase
      end

      if (!enabled || !s_q.sw) begin
         s_d.pending = 1'b0;
      end
      s_d.stretch = s_d.pending & s_q.sw & s_q.mode &
                    (s_q.st != ddcs_pkg::I2C_IDLE) & ~scl_s;
   end

   // -------------------------------------------------------------
   // Registers and buffer
   // -------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         s_q <= '0;
         s_q.tx_byte <= ddcs_pkg::RST_LEGACY_TX_BYTE;
         s_q.ptr <= ddcs_pkg::RST_BUFFER_POINTER;
         {s_q.size, s_q.sw, s_q.ax, s_q.d1_flag, s_q.d1_en, s_q.sw_flag,
          s_q.mode} <= ddcs_pkg::RST_CHANNEL_CONTROL[6:0];
         s_q.st <= ddcs_pkg::I2C_IDLE;
         s_q.host <= ddcs_pkg::HOST_NONE;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
         s_q.vs_p <= 1'b1;
      end else begin
         s_q <= s_d;
      end
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign o_sfr_rdata = s_q.sfr_rdata;
   assign o_xd_rdata = s_q.xd_rdata;
   assign o_xd_sel = xd_hit;
   assign o_scl = 1'b0;
   assign o_scl_oe_n = ~s_q.stretch;
   assign o_sda = 1'b0;
   assign o_sda_oe_n = ~(s_q.d1_low | s_q.i2c_low);
   assign o_shift_data = s_q.shift_data;
   assign o_irq = enabled & (s_q.d1_flag | s_q.sw_flag |
                             (s_q.pending & s_q.sw & s_q.mode));
   assign o_host_type = s_q.host;
endmodule // ddcs_top

// ### include/ddcs_pkg.sv
// Constants, register map and types of the display data channel slave.
// Assumes a processor special function register port and a 2-flop
// synchroniser on every pin input.
package ddcs_pkg;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_BUFFER_WINDOW = 8'hd4;
   localparam logic [7:0] OFS_LEGACY_TX_BYTE = 8'hd5;
   localparam logic [7:0] OFS_BUFFER_POINTER = 8'hd6;
   localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'hd7;
   // -------------------------------------------------------------
   // Channel control fields and reset values
   // -------------------------------------------------------------
   localparam int BIT_SIZE_SELECT = 6;
   localparam int BIT_SOFTWARE_SERVICE = 5;
   localparam int BIT_ADDRESS_MASK = 4;
   localparam int BIT_LEGACY_IRQ_FLAG = 3;
   localparam int BIT_LEGACY_ENABLE = 2;
   localparam int BIT_MODE_SWITCH_FLAG = 1;
   localparam int BIT_MODE = 0;
   localparam logic [7:0] RST_LEGACY_TX_BYTE = 8'h00;
   localparam logic [7:0] RST_BUFFER_POINTER = 8'h00;
   localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h00;
   // -------------------------------------------------------------
   // Buffer and link constants
   // -------------------------------------------------------------
   localparam int BUF_DEPTH = 256;
   localparam logic [7:0] MASK_SMALL = 8'h7f;
   localparam logic [7:0] MASK_LARGE = 8'hff;
   localparam logic [7:0] XDATA_PAGE = 8'hff;
   localparam logic [3:0] SYNC_CLOCKS = 4'h9;
   localparam logic [3:0] IDLE_BIT_POS = 4'h8;
   localparam logic [6:0] SLAVE_ADDR = 7'h50;
   localparam logic [6:0] AB_HOST_ADDR = 7'h37;
   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [6:0] {
      I2C_IDLE = 7'h01,
      I2C_ADDR = 7'h02,
      I2C_ACK_ADDR = 7'h04,
      I2C_TX = 7'h08,
      I2C_MACK = 7'h10,
      I2C_RX = 7'h20,
      I2C_ACK_DATA = 7'h40
   } ddcs_i2c_e;
   typedef enum logic [1:0] {
      HOST_NONE = 2'h0,
      HOST_LEGACY = 2'h1,
      HOST_DDC2B = 2'h2,
      HOST_DDC2AB = 2'h3
   } ddcs_host_e;
endpackage

// ### hdl/ddcs_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module ddcs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_q <= INIT;
         o_sync <= INIT;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule // ddcs_sync

// ### tb/ddcs_properties.sv
// Concurrent checks on the ports of the display data channel slave.
// Assumes the register and xdata ports are driven as the hand-over says.
`timescale 1ns/1ps
module ddcs_properties (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic [15:0] i_xd_addr,
   input wire logic i_xd_rd,
   input wire logic [7:0] o_xd_rdata,
   input wire logic o_xd_sel,
   input wire logic i_i2c_enable,
   input wire logic o_scl_oe_n,
   input wire logic o_sda_oe_n,
   input wire logic o_irq,
   input wire logic [1:0] o_host_type
);
   // ------------------------------------------------------------
   // Shadow of the enable and service bits
   // ------------------------------------------------------------
   logic leg_q;
   logic svc_q;
   logic en;
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         leg_q <= 1'b0;
         svc_q <= 1'b0;
      end else if (i_sfr_wr && i_sfr_addr == 8'hd7) begin
         leg_q <= i_sfr_wdata[ddcs_pkg::BIT_LEGACY_ENABLE];
         svc_q <= i_sfr_wdata[ddcs_pkg::BIT_SOFTWARE_SERVICE];
      end
   end
   assign en = leg_q | i_i2c_enable;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   chk_reset_idle: assert property (
      $fell(i_reset) |-> o_sda_oe_n && o_scl_oe_n && !o_irq
         && o_host_type == 2'h0)
      else $error("outputs not idle after reset");
   chk_rdata_hold: assert property (
      !i_sfr_rd |=> $stable(o_sfr_rdata))
      else $error("read data moved without a read");
   chk_ptr_rw: assert property (
      i_sfr_wr && i_sfr_addr == 8'hd6 ##2 i_sfr_rd && i_sfr_addr == 8'hd6
      |=> o_sfr_rdata == $past(i_sfr_wdata, 3))
      else $error("pointer readback wrong");
   chk_window_deny: assert property (
      i_sfr_rd && i_sfr_addr == 8'hd4 && !svc_q |=> o_sfr_rdata == 8'h00)
      else $error("window read not blocked");
   chk_xd_sel: assert property (
      o_xd_sel == (i_xd_addr[15:8] == 8'hff && (en || svc_q)))
      else $error("xdata select wrong");
   chk_xd_deny: assert property (
      i_xd_rd && !svc_q |=> o_xd_rdata == 8'h00)
      else $error("xdata read not blocked");
   chk_irq_off: assert property (
      (!en) [*2] |-> !o_irq)
      else $error("interrupt while disabled");
   chk_link_off: assert property (
      (!en) [*4] |-> o_sda_oe_n && o_scl_oe_n)
      else $error("link driven while disabled");
   chk_host_sticky: assert property (
      o_host_type != 2'h0 |=> o_host_type != 2'h0)
      else $error("host type lost");
endmodule // ddcs_properties
bind ddcs_top ddcs_properties u_ddcs_properties (
   .i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(i_sfr_addr),
   .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
   .o_sfr_rdata(o_sfr_rdata), .i_xd_addr(i_xd_addr), .i_xd_rd(i_xd_rd),
   .o_xd_rdata(o_xd_rdata), .o_xd_sel(o_xd_sel),
   .i_i2c_enable(i_i2c_enable), .o_scl_oe_n(o_scl_oe_n),
   .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq), .o_host_type(o_host_type));

// ### tb/ddcs_host_model.sv
// Display host model: sync clock source and two-wire master.
// Assumes pull-ups on both wires; half link period is 8 clocks.
`timescale 1ns/1ps
module ddcs_host_model (
   input wire logic i_clk,
   input wire logic i_scl_oe_n,
   input wire logic i_sda_oe_n,
   output logic o_vsync,
   output logic o_scl,
   output logic o_sda
);
   logic scl_h;
   logic sda_h;
   initial begin
      o_vsync = 1'b0;
      scl_h = 1'b1;
      sda_h = 1'b1;
   end
   // Open-drain wires with pull-ups
   assign o_scl = scl_h & i_scl_oe_n;
   assign o_sda = sda_h & i_sda_oe_n;
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic vpulse(output logic r);
      o_vsync = 1'b1;
      wt(8);
      o_vsync = 1'b0;
      wt(8);
      r = o_sda;
   endtask
   task automatic vbyte(output logic [7:0] q, output logic idle);
      for (int k = 7; k >= 0; k--) vpulse(q[k]);
      vpulse(idle);
   endtask
   task automatic start();
      sda_h = 1'b1;
      scl_h = 1'b1;
      wt(8);
      sda_h = 1'b0;
      wt(8);
      scl_h = 1'b0;
   endtask
   task automatic bitx(input logic b, output logic r);
      wt(4);
      sda_h = b;
      wt(4);
      scl_h = 1'b1;
      wt(8);
      r = o_sda;
      scl_h = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic am,
                       output logic [7:0] q, output logic ack);
      for (int k = 7; k >= 0; k--) bitx(d[k], q[k]);
      bitx(am, ack);
   endtask
   task automatic stop();
      wt(4);
      sda_h = 1'b0;
      wt(4);
      scl_h = 1'b1;
      wt(8);
      sda_h = 1'b1;
      wt(8);
   endtask
endmodule // ddcs_host_model

// ### tb/ddcs_tb_top.sv
// Self-checking bench of the display data channel slave.
// Assumes the host model on the link pins and the bound checker.
`timescale 1ns/1ps
module ddcs_tb_top;
   logic clk, reset, sfr_wr, sfr_rd, xd_wr, xd_rd, i2c_en, vs, scl, sda;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, xd_rdata, q, d, p;
   logic [15:0] xd_addr;
   logic xd_sel, scl_oe_n, sda_oe_n, irq, b;
   logic [1:0] host;
   logic [7:0] shd;
   logic [7:0] mem [256];
   logic [31:0] rng;
   int bad_count, total_checks;
   ddcs_top u_ddcs_top (.i_clk(clk), .i_reset(reset), .i_sfr_addr(sfr_addr),
      .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata),
      .o_sfr_rdata(sfr_rdata), .i_xd_addr(xd_addr), .i_xd_wr(xd_wr),
      .i_xd_rd(xd_rd), .i_xd_wdata(xd_wdata), .o_xd_rdata(xd_rdata),
      .o_xd_sel(xd_sel), .i_i2c_enable(i2c_en), .i_vsync(vs), .i_scl(scl),
      .o_scl(), .o_scl_oe_n(scl_oe_n), .i_sda(sda), .o_sda(),
      .o_sda_oe_n(sda_oe_n), .o_shift_data(shd), .o_irq(irq),
      .o_host_type(host));
   ddcs_host_model u_ddcs_host_model (.i_clk(clk), .i_scl_oe_n(scl_oe_n),
      .i_sda_oe_n(sda_oe_n), .o_vsync(vs), .o_scl(scl), .o_sda(sda));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(posedge clk);
      #1 sfr_wr = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk);
      #1 sfr_rd = 1'b0;
      v = sfr_rdata;
      @(posedge clk) #1;
   endtask
   task automatic xrd(input logic [15:0] a, output logic [7:0] v);
      xd_addr = a;
      xd_rd = 1'b1;
      @(posedge clk);
      #1 xd_rd = 1'b0;
      v = xd_rdata;
      @(posedge clk) #1;
   endtask
   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      conclude();
   end
   initial begin
      {reset, sfr_wr, sfr_rd, xd_wr, xd_rd, i2c_en} = 6'h20;
      {sfr_addr, sfr_wdata, xd_wdata, xd_addr} = 40'h0;
      rng = 32'd90351;
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      rd(8'hd5, q); chk(q, ddcs_pkg::RST_LEGACY_TX_BYTE);
      rd(8'hd6, q); chk(q, ddcs_pkg::RST_BUFFER_POINTER);
      rd(8'hd7, q); chk(q, ddcs_pkg::RST_CHANNEL_CONTROL);
      wr(8'hd5, 8'h5a); rd(8'hd5, q); chk(q, 8'h5a);
      wr(8'hd6, 8'h3c); rd(8'hd6, q); chk(q, 8'h3c);
      wr(8'hd7, 8'h60);
      wr(8'hd6, 8'h00);
      for (int i = 0; i < 256; i++) begin
         mem[i] = xs();
         wr(8'hd4, mem[i]);
      end
      rd(8'hd6, q); chk(q, 8'h00);
      for (int i = 0; i < 4; i++) begin
         p = xs();
         wr(8'hd6, p);
         rd(8'hd4, q); chk(q, mem[p]);
         rd(8'hd6, q); chk(q, p + 8'h01);
      end
      xd_addr = 16'hff33; #1 chk({7'h0, xd_sel}, 8'h01);
      d = xs();
      {xd_wdata, xd_wr} = {d, 1'b1};
      @(posedge clk);
      #1 xd_wr = 1'b0;
      mem[8'h33] = d;
      xrd(16'hff33, q); chk(q, d);
      wr(8'hd7, 8'h20);
      wr(8'hd6, 8'h7f);
      rd(8'hd4, q); chk(q, mem[127]);
      rd(8'hd6, q); chk(q, 8'h00);
      wr(8'hd7, 8'h00);
      wr(8'hd6, 8'h10);
      rd(8'hd4, q); chk(q, 8'h00);
      u_ddcs_host_model.vbyte(q, b); chk(q, 8'hff);
      rd(8'hd6, q); chk(q, 8'h10);
      xrd(16'hff10, q); chk(q, 8'h00);
      chk({7'h0, xd_sel}, 8'h00);
      wr(8'hd6, 8'h00);
      wr(8'hd7, 8'h04);
      for (int i = 0; i < 8; i++) begin
         u_ddcs_host_model.vpulse(b); chk({7'h0, b}, 8'h01);
      end
      for (int i = 0; i < 2; i++) begin
         u_ddcs_host_model.vbyte(q, b); chk(q, mem[i]);
         chk({7'h0, b}, 8'h01);
      end
      rd(8'hd6, q); chk(q, 8'h02);
      chk({6'h0, host}, {6'h0, ddcs_pkg::HOST_LEGACY});
      wr(8'hd7, 8'h00);
      d = xs();
      wr(8'hd5, d);
      wr(8'hd7, 8'h24);
      repeat (8) u_ddcs_host_model.vpulse(b);
      u_ddcs_host_model.vbyte(q, b); chk(q, d);
      rd(8'hd7, q); chk(q & 8'h08, 8'h08);
      chk({7'h0, irq}, 8'h01);
      wr(8'hd7, 8'h24); rd(8'hd7, q); chk(q & 8'h08, 8'h00);
      wr(8'hd7, 8'h04);
      i2c_en = 1'b1;
      u_ddcs_host_model.start();
      rd(8'hd7, q); chk(q & 8'h03, 8'h03);
      chk({7'h0, irq}, 8'h01);
      p = xs() & 8'h3f;
      u_ddcs_host_model.xfer(8'ha0, 1'b1, q, b);
      chk({7'h0, b}, 8'h00);
      u_ddcs_host_model.xfer(p, 1'b1, q, b);
      u_ddcs_host_model.stop();
      u_ddcs_host_model.start();
      u_ddcs_host_model.xfer(8'ha1, 1'b1, q, b);
      chk({7'h0, b}, 8'h00);
      u_ddcs_host_model.xfer(8'hff, 1'b0, q, b); chk(q, mem[p]);
      u_ddcs_host_model.xfer(8'hff, 1'b1, q, b); chk(q, mem[p + 1]);
      u_ddcs_host_model.stop();
      u_ddcs_host_model.start();
      u_ddcs_host_model.xfer(8'ha6, 1'b1, q, b);
      chk({7'h0, b}, 8'h01);
      u_ddcs_host_model.stop();
      wr(8'hd7, 8'h14);
      u_ddcs_host_model.start();
      u_ddcs_host_model.xfer(8'ha6, 1'b1, q, b);
      chk({7'h0, b}, 8'h00);
      u_ddcs_host_model.stop();
      rd(8'hd7, q); chk(q & 8'h01, 8'h01);
      chk({6'h0, host}, {6'h0, ddcs_pkg::HOST_DDC2B});
      wr(8'hd7, 8'h20);
      u_ddcs_host_model.start();
      u_ddcs_host_model.xfer(8'ha1, 1'b1, q, b);
      u_ddcs_host_model.wt(8); chk({7'h0, scl_oe_n}, 8'h00);
      chk(shd, d);
      chk({7'h0, irq}, 8'h01);
      wr(8'hd5, d); chk({7'h0, scl_oe_n}, 8'h01);
      u_ddcs_host_model.xfer(8'hff, 1'b1, q, b); chk(q, d);
      u_ddcs_host_model.stop();
      i2c_en = 1'b0;
      wr(8'hd7, 8'h00);
      rd(8'hd7, q); chk(q & 8'h01, 8'h00);
      conclude();
   end
endmodule // ddcs_tb_top
